// *** fwc_ctrl.v ***
// flash write controller: command, address, data byte pairing, flash program/erase
// assumes cpu/dma writes are single-cycle strobes on CLK_SYS, flash array is external
`timescale 1ns/1ps
`include "fwc_map.vh"
module fwc_ctrl #(
    parameter ADDR_W = 15,
    parameter PAGES = 32,
    parameter ERASE_CYCLES = (`FWC_ERASE_NS / 1000) * `FWC_CLK_MHZ,
    parameter PROG_CYCLES = (`FWC_PROG_NS / 1000) * `FWC_CLK_MHZ
) (
    input wire CLK_SYS,
    input wire RESET_N,
    input wire CMD_WE,
    input wire [7:0] CMD_WDATA,
    output wire [7:0] FLASH_COMMAND_REG,
    input wire ADDR_HIGH_WE,
    input wire ADDR_LOW_WE,
    input wire [7:0] ADDR_WDATA,
    output wire [7:0] FLASH_ADDR_HIGH,
    output wire [7:0] FLASH_ADDR_LOW,
    input wire TIMING_WE,
    input wire [5:0] TIMING_WDATA,
    output wire [5:0] WRITE_TIMING_REG,
    input wire DATA_WE,
    input wire [7:0] FLASH_WRITE_DATA_REG,
    input wire DMA_ARMED,
    output wire FLASH_DATA_DMA_TRIGGER,
    input wire CPU_FLASH_ACCESS,
    output wire ACCESS_VIOLATION,
    output wire CPU_FLASH_BLOCK,
    output wire SINGLE_WRITE_BUSY,
    output wire FLASH_PROG,
    output wire FLASH_ERASE,
    output wire [ADDR_W-1:0] FLASH_ADDR,
    output wire [15:0] FLASH_WDATA,
    output wire [5:0] FLASH_PAGE
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ERASE = 3'd1;
    localparam ST_WRITE = 3'd2;
    localparam ST_PROG = 3'd3;
    localparam [21:0] ERASE_CNT = ERASE_CYCLES[21:0];
    localparam [21:0] PROG_BASE = PROG_CYCLES[21:0];

    reg [2:0] state_q;
    reg [7:0] addr_hi_q;
    reg [7:0] addr_lo_q;
    reg [5:0] wt_q;
    reg [7:0] low_byte_q;
    reg have_low_q;
    reg write_pend_q;
    reg prog_q;
    reg erase_q;
    reg [15:0] wdata_q;
    reg [ADDR_W-1:0] faddr_q;
    reg trig_q;
    reg viol_q;
    reg [21:0] load_cycles;
    reg timer_load;
    wire timer_done;
    wire busy;
    wire sw_busy;
    wire [ADDR_W-1:0] word_addr;
    reg [2:0] state_d;
    reg [7:0] addr_hi_d;
    reg [7:0] addr_lo_d;
    reg [5:0] wt_d;
    reg [7:0] low_byte_d;
    reg have_low_d;
    reg write_pend_d;
    reg prog_d;
    reg erase_d;
    reg [15:0] wdata_d;
    reg [ADDR_W-1:0] faddr_d;
    reg trig_d;
    reg viol_d;
    reg [7:0] cmd_view;
    wire start_erase;
    wire start_write;
    wire pair_done;

    // word address from high:low, byte address = word * 2
    assign word_addr = {addr_hi_q[ADDR_W-9:0], addr_lo_q}; // R5

    // one command bit; shared by the timer load and the state machine
    function cmd_has;
        input [7:0] cmd;
        input integer pos;
        begin
            cmd_has = cmd[pos];
        end
    endfunction

    // erase wins over write in one command; the write waits for the erase
    assign start_erase = (state_q == ST_IDLE) && CMD_WE
        && cmd_has(CMD_WDATA, `FWC_CMD_ERASE);
    assign start_write = (state_q == ST_IDLE) && CMD_WE
        && cmd_has(CMD_WDATA, `FWC_CMD_WRITE);
    assign pair_done = (state_q == ST_WRITE) && DATA_WE && have_low_q;

    fwc_timer #(
        .WIDTH(22)
    ) u_timer (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .load(timer_load),
        .cycles(load_cycles),
        .done(timer_done)
    );

    assign sw_busy = (state_q == ST_PROG); // R6
    assign busy = (state_q != ST_IDLE);

    always @* begin
        timer_load = 1'b0;
        load_cycles = PROG_BASE; // R4
        if (start_erase) begin
            timer_load = 1'b1;
            load_cycles = ERASE_CNT; // R3
        end else if (pair_done) begin
            timer_load = 1'b1; // R7
            load_cycles = PROG_BASE;
        end
    end

    always @* begin
        state_d = state_q;
        addr_hi_d = addr_hi_q;
        addr_lo_d = addr_lo_q;
        wt_d = wt_q;
        low_byte_d = low_byte_q;
        have_low_d = have_low_q;
        write_pend_d = write_pend_q;
        prog_d = 1'b0;
        erase_d = 1'b0;
        wdata_d = wdata_q;
        faddr_d = faddr_q;
        trig_d = 1'b0;
        // a violation pulses on any flash access while word busy
        viol_d = CPU_FLASH_ACCESS && sw_busy; // R11
        // settings frozen while busy so a running word keeps its address
        if (TIMING_WE && !busy) begin
            wt_d = TIMING_WDATA;
        end
        if (ADDR_HIGH_WE && !busy) begin
            addr_hi_d = ADDR_WDATA;
        end
        if (ADDR_LOW_WE && !busy) begin
            addr_lo_d = ADDR_WDATA;
        end
        case (state_q)
            ST_IDLE: begin
                have_low_d = 1'b0;
                if (start_erase) begin
                    erase_d = 1'b1; // R18
                    write_pend_d = cmd_has(CMD_WDATA, `FWC_CMD_WRITE); // R19
                    state_d = ST_ERASE;
                end else if (start_write) begin
                    state_d = ST_WRITE; // R5
                    trig_d = DMA_ARMED; // R14
                end
            end
            ST_ERASE: begin
                if (timer_done) begin
                    write_pend_d = 1'b0;
                    if (write_pend_q) begin
                        state_d = ST_WRITE; // R19
                        trig_d = DMA_ARMED; // R14
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_WRITE: begin
                if (DATA_WE) begin
                    if (!have_low_q) begin
                        low_byte_d = FLASH_WRITE_DATA_REG; // R21
                        have_low_d = 1'b1;
                        trig_d = 1'b1; // R12
                    end else begin
                        // second byte is the high half of the word
                        wdata_d = {FLASH_WRITE_DATA_REG, low_byte_q}; // R2 R21
                        faddr_d = word_addr;
                        prog_d = 1'b1; // R7
                        have_low_d = 1'b0;
                        state_d = ST_PROG; // R10
                    end
                end
            end
            ST_PROG: begin
                // bytes arriving here are dropped; the feeder waits for the next trigger
                if (timer_done) begin
                    // address steps one word; sequence stays open
                    {addr_hi_d, addr_lo_d} = {addr_hi_q, addr_lo_q} + 16'h0001; // R8 R21
                    state_d = ST_WRITE;
                    trig_d = 1'b1; // R12
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            addr_hi_q <= 8'h00;
            addr_lo_q <= 8'h00;
            wt_q <= `FWC_WT_RESET; // R20
            low_byte_q <= 8'h00;
            have_low_q <= 1'b0;
            write_pend_q <= 1'b0;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            wdata_q <= 16'h0000;
            faddr_q <= {ADDR_W{1'b0}};
            trig_q <= 1'b0;
            viol_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_hi_q <= addr_hi_d;
            addr_lo_q <= addr_lo_d;
            wt_q <= wt_d;
            low_byte_q <= low_byte_d;
            have_low_q <= have_low_d;
            write_pend_q <= write_pend_d;
            prog_q <= prog_d;
            erase_q <= erase_d;
            wdata_q <= wdata_d;
            faddr_q <= faddr_d;
            trig_q <= trig_d;
            viol_q <= viol_d;
        end
    end

    // limitation: the sequence stays open until reset; commands only in idle
    always @* begin
        cmd_view = 8'h00;
        cmd_view[`FWC_CMD_BUSY] = busy; // R16
        cmd_view[`FWC_CMD_SWBUSY] = sw_busy; // R6
        cmd_view[`FWC_CMD_WRITE] = (state_q == ST_WRITE) || (state_q == ST_PROG)
            || write_pend_q;
        cmd_view[`FWC_CMD_ERASE] = (state_q == ST_ERASE);
    end
    assign FLASH_COMMAND_REG = cmd_view;
    assign FLASH_ADDR_HIGH = addr_hi_q;
    assign FLASH_ADDR_LOW = addr_lo_q;
    assign WRITE_TIMING_REG = wt_q;
    assign FLASH_DATA_DMA_TRIGGER = trig_q;
    assign ACCESS_VIOLATION = viol_q;
    assign CPU_FLASH_BLOCK = busy; // R9
    assign SINGLE_WRITE_BUSY = sw_busy; // R6
    assign FLASH_PROG = prog_q;
    assign FLASH_ERASE = erase_q;
    assign FLASH_ADDR = faddr_q;
    assign FLASH_WDATA = wdata_q;
    assign FLASH_PAGE = addr_hi_q[`FWC_PAGE_HI:`FWC_PAGE_LO]; // R1 R18
endmodule // fwc_ctrl

// *** fwc_map.vh ***
// flash write controller constants: command bits, field positions, timing figures
// assumes a 200 MHz system clock; included by both design files
//
// How it works
// (R1) flash is 8, 16 or 32 pages of 1024 bytes
// (R2) reads are per byte, programming per 16-bit word
// (R3) a page erase takes about 20 ms
// (R4) one word program takes about 20 us
// (R5) write bit starts sequence at high:low address
// (R6) busy flag high during each word program
// (R7) every second data byte programs one word
// (R8) any number of words; pages must be erased
// (R9) no flash fetch while writing; run from RAM
// (R10) cpu continues after data write, no stall
// (R11) flash access while busy is a violation
// (R12) dma trigger raised when data register ready
// (R13) dma uses block-to-fixed single byte transfers
// (R14) armed dma gets first trigger at start
// (R15) cpu polls busy before the next two bytes
// (R16) software waits for bit 7 clear first
// (R17) example starts write with command value 02h
// (R18) erase bit erases page from high address [6:1]
// (R19) erase and write together: erase goes first
// (R20) timing value 21000*F/16e9, reset 0x11
// (R21) first byte low address, then address steps a word
`ifndef FWC_MAP_VH
`define FWC_MAP_VH
`define FWC_CMD_ERASE 0
`define FWC_CMD_WRITE 1
`define FWC_CMD_SWBUSY 6
`define FWC_CMD_BUSY 7
`define FWC_PAGE_BYTES 1024
`define FWC_PAGE_HI 6
`define FWC_PAGE_LO 1
`define FWC_WT_RESET 6'h11
`define FWC_ERASE_NS 20000000
`define FWC_PROG_NS 20000
`define FWC_CLK_MHZ 200
`define FWC_WT_BASE 6'h11
`endif

// *** fwc_timer.v ***
// countdown timer for erase and word-program durations
// assumes load is a single-cycle pulse on the system clock
`timescale 1ns/1ps
`include "fwc_map.vh"
module fwc_timer #(
    parameter WIDTH = 22
) (
    input wire clk,
    input wire reset_n,
    input wire load,
    input wire [WIDTH-1:0] cycles,
    output wire done
);
    reg [WIDTH-1:0] cnt_q;
    reg run_q;
    reg done_q;
    always @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= {WIDTH{1'b0}};
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (load) begin
                cnt_q <= cycles;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
    assign done = done_q;
endmodule // fwc_timer

// *** fwc_ctrl_asserts.sv ***
// port checker for the flash write controller
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module fwc_ctrl_asserts (
    input wire CLK_SYS,
    input wire RESET_N,
    input wire CMD_WE,
    input wire [7:0] CMD_WDATA,
    input wire [7:0] FLASH_COMMAND_REG,
    input wire [7:0] FLASH_ADDR_HIGH,
    input wire [5:0] WRITE_TIMING_REG,
    input wire DMA_ARMED,
    input wire FLASH_DATA_DMA_TRIGGER,
    input wire CPU_FLASH_ACCESS,
    input wire ACCESS_VIOLATION,
    input wire CPU_FLASH_BLOCK,
    input wire SINGLE_WRITE_BUSY,
    input wire FLASH_PROG,
    input wire FLASH_ERASE,
    input wire [5:0] FLASH_PAGE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    a_first_trigger: assert property (CMD_WE && CMD_WDATA[1:0] == 2'b10 && DMA_ARMED
        && !FLASH_COMMAND_REG[7] |=> FLASH_DATA_DMA_TRIGGER) else $error("no first trigger");
    a_trigger_pulse: assert property (FLASH_DATA_DMA_TRIGGER |=> !FLASH_DATA_DMA_TRIGGER)
        else $error("trigger too long");
    a_word_retrigger: assert property ($fell(SINGLE_WRITE_BUSY) |-> ##[0:3] FLASH_DATA_DMA_TRIGGER)
        else $error("no trigger after word");
    a_prog_busy: assert property (FLASH_PROG |-> SINGLE_WRITE_BUSY[*5]) else $error("busy short");
    a_busy_bit: assert property (SINGLE_WRITE_BUSY == FLASH_COMMAND_REG[6])
        else $error("busy bit differs");
    a_busy_violation: assert property (CPU_FLASH_ACCESS && SINGLE_WRITE_BUSY |=> ACCESS_VIOLATION)
        else $error("violation missed");
    a_no_violation: assert property (!CPU_FLASH_ACCESS |=> !ACCESS_VIOLATION)
        else $error("false violation");
    a_fetch_block: assert property (SINGLE_WRITE_BUSY |-> CPU_FLASH_BLOCK) else $error("no block");
    a_erase_page: assert property (FLASH_ERASE |-> FLASH_PAGE == FLASH_ADDR_HIGH[6:1]
        && $past(CMD_WE && CMD_WDATA[0] && !FLASH_COMMAND_REG[7])) else $error("wrong page");
    a_timing_reset: assert property ($rose(RESET_N) |-> WRITE_TIMING_REG == 6'h11)
        else $error("timing reset value");
    cover property (FLASH_PROG);
    cover property (FLASH_ERASE);
    cover property (ACCESS_VIOLATION);
endmodule // fwc_ctrl_asserts
bind fwc_ctrl fwc_ctrl_asserts fwc_ctrl_asserts_inst (.*);

// *** fwc_feeder.sv ***
// byte source standing in for the dma channel feeding the data register
// assumes trigger pulses on the rising edge; count restarts while disarmed
`timescale 1ns/1ps
module fwc_feeder (
    input wire clk,
    input wire armed,
    input wire slow,
    input wire trigger,
    output reg we,
    output reg [7:0] data
);
    reg [7:0] n_q = 8'h00;
    integer wait_q = -1;
    initial we = 1'b0;
    initial data = 8'h00;
    always @(posedge clk) begin
        we <= 1'b0;
        data <= ~data; // idle bus inverts each cycle, so it shows the last byte only every other cycle
        if (!armed) begin
            n_q <= 8'h00;
            wait_q <= -1;
        end else if (trigger) begin
            wait_q <= slow ? 4 : 0;
        end else if (wait_q == 0) begin
            we <= 1'b1;
            data <= 8'ha0 + n_q;
            n_q <= n_q + 8'h01;
            wait_q <= -1;
        end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end
    end
endmodule // fwc_feeder

// *** test_flash_write_controller.sv ***
// bench: dma and cpu fed writes, erase then write, access while busy
// assumes short erase and program counts for the controller
`timescale 1ns/1ps
module test_flash_write_controller;
    logic clk = 1'b0, rst_n = 1'b0, cmd_we = 1'b0, ah_we = 1'b0, al_we = 1'b0, t_we = 1'b0;
    logic cpu_we = 1'b0, armed = 1'b0, slow = 1'b0, access = 1'b0;
    logic [7:0] bus = 8'h00;
    wire f_we, trig, busy, prog, erase, viol, blk;
    wire [7:0] f_data, cmd_r, al_r, ah_r;
    wire [5:0] wt_r, page;
    logic [5:0] erase_pg;
    wire [14:0] faddr;
    wire [15:0] wdata;
    logic [15:0] got_w[$];
    logic [14:0] got_a[$];
    int erase_n, early_n, viol_n, failures, total_checks;
    fwc_ctrl #(.ERASE_CYCLES(20), .PROG_CYCLES(5)) fwc_ctrl_inst (.CLK_SYS(clk),
        .RESET_N(rst_n), .CMD_WE(cmd_we), .CMD_WDATA(bus), .FLASH_COMMAND_REG(cmd_r),
        .ADDR_HIGH_WE(ah_we), .ADDR_LOW_WE(al_we), .ADDR_WDATA(bus), .FLASH_ADDR_HIGH(ah_r),
        .FLASH_ADDR_LOW(al_r), .TIMING_WE(t_we), .TIMING_WDATA(bus[5:0]),
        .WRITE_TIMING_REG(wt_r), .DATA_WE(armed ? f_we : cpu_we),
        .FLASH_WRITE_DATA_REG(armed ? f_data : bus), .DMA_ARMED(armed),
        .FLASH_DATA_DMA_TRIGGER(trig), .CPU_FLASH_ACCESS(access), .ACCESS_VIOLATION(viol),
        .CPU_FLASH_BLOCK(blk), .SINGLE_WRITE_BUSY(busy), .FLASH_PROG(prog), .FLASH_ERASE(erase),
        .FLASH_ADDR(faddr), .FLASH_WDATA(wdata), .FLASH_PAGE(page));
    fwc_feeder fwc_feeder_inst (.clk(clk), .armed(armed), .slow(slow), .trigger(trig),
        .we(f_we), .data(f_data));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (prog) got_w.push_back(wdata);
        if (prog) got_a.push_back(faddr);
        if (erase) erase_n++;
        if (erase) erase_pg = page;
        if (prog && erase_n == 0) early_n++;
        if (viol) viol_n++;
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task poke(input int sel, input logic [7:0] d);
        if (sel == 0) ready_wait();
        @(negedge clk);
        bus = d;
        {cmd_we, ah_we, al_we, t_we, cpu_we} = 5'h10 >> sel;
        @(negedge clk);
        {cmd_we, ah_we, al_we, t_we, cpu_we} = 5'h00;
    endtask
    // software polls the busy bit before each command
    task ready_wait;
        int i;
        for (i = 0; i < 100 && cmd_r[7] !== 1'b0; i++) @(negedge clk);
        if (i == 100) begin
            failures++;
            close_out();
        end
    endtask
    task rst;
        @(negedge clk);
        rst_n = 1'b0;
        armed = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        got_w.delete();
        got_a.delete();
        erase_n = 0;
        early_n = 0;
        viol_n = 0;
    endtask
    // stop feeding once enough words landed, then wait for the word to finish
    task waitw(input int n);
        int i;
        for (i = 0; i < 3000 && (got_w.size() < n || busy !== 1'b0); i++) begin
            if (got_w.size() >= n) armed = 1'b0;
            @(negedge clk);
        end
        if (i == 3000) begin
            failures++;
            close_out();
        end
    endtask
    initial begin
        rst();
        chk("timing reset", wt_r, 6'h11);
        chk("command reset", cmd_r, 8'h00);
        poke(1, 8'h00);
        poke(2, 8'h01);
        poke(3, 8'h2a);
        chk("timing", wt_r, 6'h2a);
        armed = 1'b1;
        access = 1'b1;
        poke(0, 8'h02);
        waitw(2);
        access = 1'b0;
        chk("word0", got_w[0], 16'ha1a0);
        chk("addr0", got_a[0], 15'h0001);
        chk("word1", got_w[1], 16'ha3a2);
        chk("addr1", got_a[1], 15'h0002);
        chk("addr low", al_r, 8'h03);
        chk("violations", viol_n > 0, 1);
        chk("fetch block", blk, 1'b1);
        rst();
        poke(1, 8'h06);
        poke(2, 8'h00);
        slow = 1'b1;
        armed = 1'b1;
        poke(0, 8'h03);
        waitw(1);
        chk("erases", erase_n, 1);
        chk("prog before erase", early_n, 0);
        chk("erase write addr", got_a[0], 15'h0600);
        chk("erase page", erase_pg, 6'h03);
        chk("addr high", ah_r, 8'h06);
        rst();
        poke(1, 8'h00);
        poke(2, 8'h10);
        poke(0, 8'h02);
        chk("command write", cmd_r, 8'h82);
        poke(4, 8'h12);
        poke(4, 8'h34);
        waitw(1);
        poke(4, 8'h56);
        poke(4, 8'h78);
        waitw(2);
        chk("cpu word0", got_w[0], 16'h3412);
        chk("cpu word1", got_w[1], 16'h7856);
        chk("cpu addr1", got_a[1], 15'h0011);
        close_out();
    end
endmodule // test_flash_write_controller
